// file: design/idmu_pkg.sv
// Shared encodings, widths and carriers for the integer divide unit
package idmu_pkg;

  // Operand and result width
  localparam int unsigned XLEN = 64;
  // Half width used by the word variants
  localparam int unsigned WLEN = 32;

  // Major opcode shared by every divide variant
  localparam logic [5:0] MAJOR_OPCODE = 6'h00;
  // Function codes, bits 5..0
  localparam logic [5:0] WORD_SIGNED_FUNCTION_CODE = 6'h1a;
  localparam logic [5:0] WORD_UNSIGNED_FUNCTION_CODE = 6'h1b;
  localparam logic [5:0] DWORD_SIGNED_FUNCTION_CODE = 6'h1e;
  localparam logic [5:0] DWORD_UNSIGNED_FUNCTION_CODE = 6'h1f;
  // Sub-codes in bits 10..6
  localparam logic [4:0] SUB_QUOTIENT = 5'h02;
  localparam logic [4:0] SUB_REMAINDER = 5'h03;
  // Older two-operand form has bits 15..6 all zero
  localparam logic [9:0] LEGACY_ZERO_FIELD = 10'h000;

  // Iteration counts, one quotient bit per clock
  localparam logic [6:0] WORD_STEPS = 7'h20;
  localparam logic [6:0] DWORD_STEPS = 7'h40;

  // Reset values
  localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;
  localparam logic [4:0] DEST_RESET = 5'h00;
  localparam logic [6:0] COUNT_RESET = 7'h00;

  // Unit sequencer states
  typedef enum logic [1:0] {
    IDMU_IDLE = 2'b00,
    IDMU_RUN = 2'b01,
    IDMU_FIX = 2'b10
  } idmu_state_e;

  // Instruction and operands from the issue stage
  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] dividend;
    logic [63:0] divisor;
  } idmu_req_s;

  // Single result toward the general register file
  typedef struct packed {
    logic [4:0] dest;
    logic [63:0] data;
  } idmu_wb_s;

endpackage : idmu_pkg

// file: design/idmu_divide_unit.sv
// Overview of operation
// - Decode signed word quotient/remainder, function 011010
// - Decode unsigned word quotient/remainder, function 011011
// - Decode signed doubleword quotient/remainder, function 011110
// - Decode unsigned doubleword quotient/remainder, function 011111
// - Truncated division; remainder takes dividend sign
// - Zero divisor gives any value, completes normally
// - Word variants never raise arithmetic exceptions
// - Unsigned word ignores operand bits 32-63
// - Word results sign-extended from bit 31
// - Doubleword variants trap unless 64-bit enabled
// - Doubleword variants write full 64-bit result
// - One result only; legacy result registers untouched
// - Older two-operand divide encodings trap as reserved
`timescale 1ns/1ps
`default_nettype none

module idmu_divide_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire idmu_pkg::idmu_req_s issue_req,
  input wire logic dword_ops_enabled,
  output logic issue_ready,
  output logic wb_valid,
  output idmu_pkg::idmu_wb_s wb_out,
  output logic rsvd_exc,
  output logic pending_valid,
  output logic [4:0] pending_dest
);

  // Instruction fields
  logic [5:0] major_op;
  logic [4:0] dividend_reg_field;
  logic [4:0] divisor_reg_field;
  logic [4:0] dest_field;
  logic [4:0] sub_code;
  logic [5:0] func_code;
  assign major_op = issue_req.instr[31:26];
  assign dividend_reg_field = issue_req.instr[25:21];
  assign divisor_reg_field = issue_req.instr[20:16];
  assign dest_field = issue_req.instr[15:11];
  assign sub_code = issue_req.instr[10:6];
  assign func_code = issue_req.instr[5:0];

  // Decoded class of the offered instruction
  logic is_word_signed;
  logic is_word_unsigned;
  logic is_dword_signed;
  logic is_dword_unsigned;
  logic sub_ok;
  logic is_div_family;
  logic is_legacy;
  logic is_dword;
  logic is_signed;
  logic want_rem;
  logic decode_ok;
  logic decode_trap;

  // Opcode and function decode
  always_comb begin
    sub_ok = (sub_code == idmu_pkg::SUB_QUOTIENT) || (sub_code == idmu_pkg::SUB_REMAINDER);
    is_word_signed = (func_code == idmu_pkg::WORD_SIGNED_FUNCTION_CODE);
    is_word_unsigned = (func_code == idmu_pkg::WORD_UNSIGNED_FUNCTION_CODE);
    is_dword_signed = (func_code == idmu_pkg::DWORD_SIGNED_FUNCTION_CODE);
    is_dword_unsigned = (func_code == idmu_pkg::DWORD_UNSIGNED_FUNCTION_CODE);
    is_div_family = (major_op == idmu_pkg::MAJOR_OPCODE) &&
                    (is_word_signed || is_word_unsigned || is_dword_signed || is_dword_unsigned);
    // Older form: rd/sub-code field all zero, results to upper/bottom pair
    is_legacy = is_div_family &&
                (issue_req.instr[15:6] == idmu_pkg::LEGACY_ZERO_FIELD);
    is_dword = is_dword_signed || is_dword_unsigned;
    is_signed = is_word_signed || is_dword_signed;
    want_rem = (sub_code == idmu_pkg::SUB_REMAINDER);
    // Doubleword forms are only legal with 64-bit operations on
    decode_ok = is_div_family && sub_ok && !(is_dword && !dword_ops_enabled);
    // Anything else offered to this unit is a reserved instruction
    decode_trap = !decode_ok || is_legacy;
  end

  // Operand magnitudes and signs at issue
  logic a_neg;
  logic b_neg;
  logic [63:0] a_mag;
  logic [63:0] b_mag;
  logic [31:0] a_word;
  logic [31:0] b_word;

  // Word forms look at bits 31..0 only, upper half discarded
  always_comb begin
    a_word = issue_req.dividend[31:0];
    b_word = issue_req.divisor[31:0];
    if (is_dword) begin
      a_neg = is_signed && issue_req.dividend[63];
      b_neg = is_signed && issue_req.divisor[63];
      a_mag = a_neg ? (64'h0000_0000_0000_0000 - issue_req.dividend) : issue_req.dividend;
      b_mag = b_neg ? (64'h0000_0000_0000_0000 - issue_req.divisor) : issue_req.divisor;
    end else begin
      a_neg = is_signed && a_word[31];
      b_neg = is_signed && b_word[31];
      // Magnitude of the most negative word still fits 32 unsigned bits
      a_mag = {32'h0000_0000, a_neg ? (32'h0000_0000 - a_word) : a_word};
      b_mag = {32'h0000_0000, b_neg ? (32'h0000_0000 - b_word) : b_word};
    end
  end

  logic accept;
  assign accept = issue_valid && issue_ready;

  // Sequencer state
  idmu_pkg::idmu_state_e state_reg;
  idmu_pkg::idmu_state_e state_next;
  logic [6:0] count_reg;
  logic last_step;
  assign last_step = (count_reg == 7'h01);

  // Next state: trapping instructions never leave idle
  always_comb begin
    case (state_reg)
      idmu_pkg::IDMU_IDLE: begin
        state_next = (accept && !decode_trap) ? idmu_pkg::IDMU_RUN : idmu_pkg::IDMU_IDLE;
      end
      idmu_pkg::IDMU_RUN: begin
        // Fixed length, so a zero divisor still finishes
        state_next = last_step ? idmu_pkg::IDMU_FIX : idmu_pkg::IDMU_RUN;
      end
      idmu_pkg::IDMU_FIX: begin
        state_next = idmu_pkg::IDMU_IDLE;
      end
      default: begin
        state_next = idmu_pkg::IDMU_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= idmu_pkg::IDMU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latched operation attributes
  logic dword_reg;
  logic want_rem_reg;
  logic q_neg_reg;
  logic r_neg_reg;
  logic [4:0] dest_reg;

  // Captured once per accepted instruction that does not trap
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dword_reg <= 1'b0;
      want_rem_reg <= 1'b0;
      q_neg_reg <= 1'b0;
      r_neg_reg <= 1'b0;
      dest_reg <= idmu_pkg::DEST_RESET;
    end else if (accept && !decode_trap) begin
      dword_reg <= is_dword;
      want_rem_reg <= want_rem;
      // Truncation: quotient sign is the xor, remainder follows dividend
      q_neg_reg <= a_neg ^ b_neg;
      r_neg_reg <= a_neg;
      dest_reg <= dest_field;
    end
  end

  // Restoring divider datapath
  logic [63:0] rem_reg;
  logic [63:0] quo_reg;
  logic [63:0] dvs_reg;
  logic [64:0] rem_shift;
  logic [64:0] trial;

  // One restoring step: shift in next dividend bit and try subtract
  always_comb begin
    rem_shift = {rem_reg, quo_reg[63]};
    trial = rem_shift - {1'b0, dvs_reg};
  end

  // Iteration counter, 32 steps for words and 64 for doublewords
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_reg <= idmu_pkg::COUNT_RESET;
    end else if (accept && !decode_trap) begin
      count_reg <= is_dword ? idmu_pkg::DWORD_STEPS : idmu_pkg::WORD_STEPS;
    end else if (state_reg == idmu_pkg::IDMU_RUN) begin
      count_reg <= count_reg - 7'h01;
    end
  end

  // Partial remainder and quotient shift register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rem_reg <= idmu_pkg::DATA_RESET;
      quo_reg <= idmu_pkg::DATA_RESET;
      dvs_reg <= idmu_pkg::DATA_RESET;
    end else if (accept && !decode_trap) begin
      rem_reg <= idmu_pkg::DATA_RESET;
      // Word dividend sits at the top so its MSB shifts out first
      quo_reg <= is_dword ? a_mag : {a_mag[31:0], 32'h0000_0000};
      dvs_reg <= b_mag;
    end else if (state_reg == idmu_pkg::IDMU_RUN) begin
      if (!trial[64]) begin
        rem_reg <= trial[63:0];
        quo_reg <= {quo_reg[62:0], 1'b1};
      end else begin
        rem_reg <= rem_shift[63:0];
        quo_reg <= {quo_reg[62:0], 1'b0};
      end
    end
  end

  // Sign fix and width shaping of the final result
  logic [63:0] q_fix;
  logic [63:0] r_fix;
  logic [31:0] q_word;
  logic [31:0] r_word;
  logic [63:0] result;

  always_comb begin
    q_fix = q_neg_reg ? (64'h0000_0000_0000_0000 - quo_reg) : quo_reg;
    r_fix = r_neg_reg ? (64'h0000_0000_0000_0000 - rem_reg) : rem_reg;
    q_word = q_neg_reg ? (32'h0000_0000 - quo_reg[31:0]) : quo_reg[31:0];
    r_word = r_neg_reg ? (32'h0000_0000 - rem_reg[31:0]) : rem_reg[31:0];
    if (dword_reg) begin
      // Full width, no extension or truncation
      result = want_rem_reg ? r_fix : q_fix;
    end else if (want_rem_reg) begin
      result = {{32{r_word[31]}}, r_word};
    end else begin
      result = {{32{q_word[31]}}, q_word};
    end
  end

  // Write-back port: one destination, one value, single pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wb_valid <= 1'b0;
      wb_out <= '0;
    end else if (state_reg == idmu_pkg::IDMU_FIX) begin
      // Only quotient or remainder, never both; no upper/bottom pair here
      wb_valid <= 1'b1;
      wb_out.dest <= dest_reg;
      wb_out.data <= result;
    end else begin
      wb_valid <= 1'b0;
    end
  end

  // Reserved instruction pulse, no write follows it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsvd_exc <= 1'b0;
    end else begin
      rsvd_exc <= accept && decode_trap;
    end
  end

  // Ready falls on a good accept and returns once the write issues
  always_ff @(posedge clk) begin
    if (!resetn) begin
      issue_ready <= 1'b0;
    end else begin
      issue_ready <= (state_next == idmu_pkg::IDMU_IDLE);
    end
  end

  // Interlock: readers of this destination must stall while set
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pending_valid <= 1'b0;
      pending_dest <= idmu_pkg::DEST_RESET;
    end else if (accept && !decode_trap) begin
      pending_valid <= 1'b1;
      pending_dest <= dest_field;
    end else if (state_reg == idmu_pkg::IDMU_FIX) begin
      // Drops together with the write-back pulse rising
      pending_valid <= 1'b0;
    end
  end

  // Register source fields are resolved by the pipeline, kept for clarity
  logic unused_fields;
  assign unused_fields = ^{dividend_reg_field, divisor_reg_field};

endmodule : idmu_divide_unit

`default_nettype wire

// file: testbench/idmu_divide_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module idmu_divide_unit_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire idmu_pkg::idmu_req_s issue_req,
  input wire logic dword_ops_enabled,
  input wire logic issue_ready,
  input wire logic wb_valid,
  input wire idmu_pkg::idmu_wb_s wb_out,
  input wire logic rsvd_exc,
  input wire logic pending_valid,
  input wire logic [4:0] pending_dest
);
  // Accepted offer, split into legal word, legal doubleword and trapped
  logic acc, ok_w, ok_d, bad, dw_off, word_reg;
  logic [31:0] ins;
  assign ins = issue_req.instr;
  assign acc = issue_valid && issue_ready;
  // Sub-code 00010 or 00011 also rules out the all-zero older form
  assign ok_w = acc && ins[31:26] == 6'h00 && ins[10:7] == 4'h1 && ins[5:1] == 5'h0d;
  assign dw_off = acc && ins[5:1] == 5'h0f && !dword_ops_enabled;
  assign ok_d = acc && ins[31:26] == 6'h00 && ins[10:7] == 4'h1 && ins[5:1] == 5'h0f
    && dword_ops_enabled;
  assign bad = acc && !ok_w && !ok_d;
  // Remembers whether the running divide is a word form
  always_ff @(posedge clk) begin
    if (!resetn) begin
      word_reg <= 1'b0;
    end else if (acc) begin
      word_reg <= ok_w;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Unit busy with a result outstanding
  sequence held_s;
    pending_valid && !issue_ready;
  endsequence
  sequence trap_s;
    rsvd_exc && issue_ready && !pending_valid && !wb_valid;
  endsequence
  word_lat_a: assert property (ok_w |=> held_s ##32 held_s ##1 wb_valid)
    else $error("word divide latency wrong");
  dword_lat_a: assert property (ok_d |=> held_s ##64 held_s ##1 wb_valid)
    else $error("doubleword divide latency wrong");
  trap_no_wb_a: assert property (bad |=> trap_s)
    else $error("bad encoding not trapped");
  dword_off_a: assert property (dw_off |-> ##1 rsvd_exc ##1 !rsvd_exc)
    else $error("disabled doubleword not trapped");
  word_no_exc_a: assert property (ok_w |=> !rsvd_exc [*8])
    else $error("word divide raised exception");
  wb_frees_a: assert property (wb_valid |-> issue_ready && !pending_valid)
    else $error("pending not cleared at write");
  pend_dest_a: assert property (ok_w || ok_d |=> pending_dest == $past(ins[15:11]))
    else $error("pending destination wrong");
  dest_match_a: assert property (wb_valid |-> wb_out.dest == $past(pending_dest))
    else $error("write destination wrong");
  word_sext_a: assert property (wb_valid && word_reg |->
    wb_out.data[63:32] == {32{wb_out.data[31]}})
    else $error("word result not sign extended");
  out_hold_a: assert property (!wb_valid |-> $stable(wb_out))
    else $error("result changed without write");
endmodule : idmu_divide_unit_properties
bind idmu_divide_unit idmu_divide_unit_properties i_props (.clk(clk), .resetn(resetn),
  .issue_valid(issue_valid), .issue_req(issue_req), .dword_ops_enabled(dword_ops_enabled),
  .issue_ready(issue_ready), .wb_valid(wb_valid), .wb_out(wb_out), .rsvd_exc(rsvd_exc),
  .pending_valid(pending_valid), .pending_dest(pending_dest));
`default_nettype wire

// file: testbench/idmu_gpr_model.sv
`timescale 1ns/1ps
`default_nettype none
module idmu_gpr_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_valid,
  input wire idmu_pkg::idmu_wb_s wb_out
);
  // General registers, written only by the unit's result port
  logic [63:0] gpr_reg [32];
  // Counts writes so a trap can be seen to leave the file alone
  int write_count_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      write_count_reg <= 0;
    end else if (wb_valid) begin
      gpr_reg[wb_out.dest] <= wb_out.data;
      write_count_reg <= write_count_reg + 1;
    end
  end
endmodule : idmu_gpr_model
`default_nettype wire

// file: testbench/integer_divide_modulo_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module integer_divide_modulo_unit_bench;
  logic clk, resetn, issue_valid, dword_ops_enabled, issue_ready, wb_valid, rsvd_exc;
  logic pending_valid;
  logic [4:0] pending_dest;
  idmu_pkg::idmu_req_s issue_req;
  idmu_pkg::idmu_wb_s wb_out;
  int mismatches, n_checks;
  always #5 clk = ~clk;
  idmu_divide_unit i_dut (.clk(clk), .resetn(resetn), .issue_valid(issue_valid),
    .issue_req(issue_req), .dword_ops_enabled(dword_ops_enabled), .issue_ready(issue_ready),
    .wb_valid(wb_valid), .wb_out(wb_out), .rsvd_exc(rsvd_exc),
    .pending_valid(pending_valid), .pending_dest(pending_dest));
  idmu_gpr_model i_gpr (.clk(clk), .resetn(resetn), .wb_valid(wb_valid), .wb_out(wb_out));
  // Single compare, narrow values are zero extended
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Reference quotient or remainder, truncating as SV division does
  function automatic logic [63:0] ref_div(input logic [5:0] f, input logic rem,
    input logic [63:0] a, input logic [63:0] b);
    logic [31:0] w;
    logic [63:0] d;
    case (f)
      6'h1a: w = rem ? $signed(a[31:0]) % $signed(b[31:0]) : $signed(a[31:0]) / $signed(b[31:0]);
      6'h1b: w = rem ? a[31:0] % b[31:0] : a[31:0] / b[31:0];
      6'h1e: d = rem ? $signed(a) % $signed(b) : $signed(a) / $signed(b);
      default: d = rem ? a % b : a / b;
    endcase
    return f[2] ? d : {{32{w[31]}}, w};
  endfunction : ref_div
  // One offer; returns trap flag or written data, checks pending on the way
  task automatic run(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
    input logic en, output logic ex, output logic [63:0] d);
    int k;
    ex = 1'b0;
    d = 64'h0;
    k = 0;
    while (issue_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k == 100) chk(64'h0, 64'h1);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_req <= '{instr: ins, dividend: a, divisor: b};
    dword_ops_enabled <= en;
    @(posedge clk);
    issue_valid <= 1'b0;
    for (k = 1; k < 80; k++) begin
      @(negedge clk);
      if (rsvd_exc === 1'b1) begin
        ex = 1'b1;
        break;
      end
      if (k == 1) chk({pending_valid, pending_dest}, {1'b1, ins[15:11]});
      if (wb_valid === 1'b1) begin
        d = wb_out.data;
        chk(wb_out.dest, ins[15:11]);
        break;
      end
    end
    if (k == 80) chk(64'h0, 64'h1);
    // Register file takes the write on the next edge, so let it pass
    @(negedge clk);
  endtask : run
  // All four quotient/remainder forms of one width, negative dividend
  task automatic sc_divide(input logic dw);
    logic ex;
    logic [63:0] d, a;
    logic [5:0] f;
    a = dw ? 64'hf000_0000_0000_0005 : 64'hffff_ffff_ffff_ff9d;
    for (int i = 0; i < 4; i++) begin
      f = {3'b011, dw, 1'b1, i[1]};
      run({6'h00, 5'h01, 5'h02, f[4:0], 4'h1, i[0], f}, a, 64'h7, dw, ex, d);
      chk(ex, 1'b0);
      chk(d, ref_div(f, i[0], a, 64'h7));
      chk(i_gpr.gpr_reg[f[4:0]], d);
    end
  endtask : sc_divide
  // Zero divisor still completes with a write and no exception
  task automatic sc_zero;
    logic ex;
    logic [63:0] d;
    int w0;
    w0 = i_gpr.write_count_reg;
    run({6'h00, 5'h01, 5'h02, 5'h09, 5'h02, 6'h1a}, 64'h5, 64'h0, 1'b1, ex, d);
    chk(ex, 1'b0);
    chk(i_gpr.write_count_reg, w0 + 1);
  endtask : sc_zero
  // Disabled doubleword and older two-operand form both trap, no write
  task automatic sc_trap;
    logic ex;
    logic [63:0] d;
    int w0;
    w0 = i_gpr.write_count_reg;
    run({6'h00, 5'h01, 5'h02, 5'h0a, 5'h03, 6'h1f}, 64'h9, 64'h2, 1'b0, ex, d);
    chk(ex, 1'b1);
    run({6'h00, 5'h01, 5'h02, 10'h000, 6'h1a}, 64'h9, 64'h2, 1'b1, ex, d);
    chk(ex, 1'b1);
    // Bad sub-code and foreign major opcode are not divides either
    run({6'h00, 5'h01, 5'h02, 5'h0b, 5'h04, 6'h1b}, 64'h9, 64'h2, 1'b1, ex, d);
    chk(ex, 1'b1);
    run({6'h01, 5'h01, 5'h02, 5'h0c, 5'h02, 6'h1a}, 64'h9, 64'h2, 1'b1, ex, d);
    chk(ex, 1'b1);
    chk(i_gpr.write_count_reg, w0);
  endtask : sc_trap
  // Hang guard, ample for a dozen divides
  initial begin
    #50000;
    chk(64'h0, 64'h1);
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    issue_valid = 1'b0;
    issue_req = '0;
    dword_ops_enabled = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk({issue_ready, wb_valid, rsvd_exc, pending_valid}, 64'h0);
    @(posedge clk);
    resetn <= 1'b1;
    sc_divide(1'b0);
    sc_divide(1'b1);
    sc_zero();
    sc_trap();
    tally_and_finish();
  end
endmodule : integer_divide_modulo_unit_bench
`default_nettype wire
